// file: sacc_regs.svh
// register offsets, reset values and timing counts for the converter control block
`ifndef SACC_REGS_SVH
`define SACC_REGS_SVH
`define SACC_ADDR_PORT_DIR 16'hFF22
`define SACC_ADDR_CHAN_SEL 16'hFF29
`define SACC_ADDR_PIN_FUNC 16'hFF2F
`define SACC_ADDR_MODE 16'hFF30
`define SACC_ADDR_RES_LO 16'hFF08
`define SACC_ADDR_RES_HI 16'hFF09
`define SACC_RST_PORT_DIR 8'hFF
`define SACC_RST_CHAN_SEL 8'h00
`define SACC_RST_PIN_FUNC 8'h00
`define SACC_MODE_START 7
`define SACC_MODE_CMP_EN 0
`define SACC_PIN_FUNC_MAX 4'h8
`define SACC_SAMPLE_CYCLES 8'h18
`endif

// file: sacc_pkg.sv
// types shared by the converter control block
package sacc_pkg;
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } sacc_bus_req_t;
    typedef enum logic [1:0] {SACC_IDLE, SACC_SAMPLE, SACC_APPROX, SACC_DONE} sacc_state_t;
endpackage

// file: sacc_ctrl.sv
// channel, pin function and successive approximation control for an eight-input converter
// Summary of operation
// - low three channel bits pick one input
// - channel or pin function write inserts wait
// - pin function k makes lowest k pins digital
// - direction bit 1 input, 0 output; reset ones
// - convert analog input pin only when selected
// - sample fixed time, then hold until done
// - start with bit 9 at half reference
// - bits 8..0 set, compare, keep or clear
// - after ten compares transfer result, raise irq
// - repeat back to back while start set
// - channel write aborts and restarts conversion
// - start cleared stops at once, result kept
// - wide result left aligned, byte holds top
`timescale 1ns/1ps
`include "sacc_regs.svh"
module sacc_ctrl #(
    parameter int RES_BITS = 10
) (
    input wire logic i_clock,
    input wire logic i_reset_n,
    input wire sacc_pkg::sacc_bus_req_t i_bus,
    input wire logic i_cmp_above,
    output logic [7:0] o_rdata,
    output logic o_wait,
    output logic [9:0] o_trial_code,
    output logic o_sample,
    output logic o_cmp_enable,
    output logic [7:0] o_analog_sel,
    output logic [7:0] o_digital_pin,
    output logic [7:0] o_output_buf_en,
    output logic o_conversion_end_irq
);
    import sacc_pkg::*;

    // the approximation datapath is built for exactly ten bits
    if (RES_BITS != 10) begin : g_res_check
        $error("only a ten-bit approximation is supported");
    end

    logic [7:0] port_direction_reg, next_port_direction_reg;
    logic [2:0] channel_select_reg, next_channel_select_reg;
    logic [3:0] pin_function_reg, next_pin_function_reg;
    logic conversion_start, next_conversion_start;
    logic comparator_enable, next_comparator_enable;
    logic [4:0] conv_time_sel, next_conv_time_sel;
    logic [9:0] approximation_reg, next_approximation_reg;
    logic [9:0] result_reg, next_result_reg;
    logic [3:0] bit_idx, next_bit_idx;
    logic [7:0] sample_cnt, next_sample_cnt;
    logic [3:0] approx_len, next_approx_len;
    sacc_state_t state, next_state;
    logic irq, next_irq;
    logic wait_q, next_wait_q;
    logic [7:0] rdata, next_rdata;
    logic wr_chan, wr_pin;

    // pin k of the shared port is digital when k is below the configured count
    function automatic logic [7:0] digital_mask(input logic [3:0] k);
        logic [7:0] m;
        m = 8'h00;
        for (int i = 0; i < 8; i++) begin
            m[i] = (4'(i) < k);
        end
        return m;
    endfunction

    assign wr_chan = i_bus.wr && (i_bus.addr == `SACC_ADDR_CHAN_SEL);
    assign wr_pin = i_bus.wr && (i_bus.addr == `SACC_ADDR_PIN_FUNC);

    // register writes and conversion sequencing
    always_comb begin
        next_port_direction_reg = port_direction_reg;
        next_channel_select_reg = channel_select_reg;
        next_pin_function_reg = pin_function_reg;
        next_conversion_start = conversion_start;
        next_comparator_enable = comparator_enable;
        next_conv_time_sel = conv_time_sel;
        next_approximation_reg = approximation_reg;
        next_result_reg = result_reg;
        next_bit_idx = bit_idx;
        next_sample_cnt = sample_cnt;
        next_state = state;
        next_irq = 1'b0;
        next_wait_q = 1'b0;
        next_rdata = rdata;
        // counts approximation cycles so the ten-step check needs no long repetition
        next_approx_len = (state == SACC_APPROX) ? approx_len + 4'h1 : 4'h0;
        if (i_bus.wr) begin
            case (i_bus.addr)
                `SACC_ADDR_PORT_DIR: next_port_direction_reg = i_bus.wdata;
                `SACC_ADDR_CHAN_SEL: next_channel_select_reg = i_bus.wdata[2:0];
                `SACC_ADDR_PIN_FUNC: begin
                    // prohibited codes are ignored so the decode never goes out of range
                    if (i_bus.wdata[3:0] <= `SACC_PIN_FUNC_MAX) begin
                        next_pin_function_reg = i_bus.wdata[3:0];
                    end
                end
                `SACC_ADDR_MODE: begin
                    next_conversion_start = i_bus.wdata[`SACC_MODE_START];
                    next_comparator_enable = i_bus.wdata[`SACC_MODE_CMP_EN];
                    next_conv_time_sel = i_bus.wdata[5:1];
                end
                default: ;
            endcase
        end
        // one wait cycle per channel or pin function write
        next_wait_q = (wr_chan || wr_pin) && !wait_q;
        if (i_bus.rd) begin
            case (i_bus.addr)
                `SACC_ADDR_PORT_DIR: next_rdata = port_direction_reg;
                `SACC_ADDR_CHAN_SEL: next_rdata = {5'h00, channel_select_reg};
                `SACC_ADDR_PIN_FUNC: next_rdata = {4'h0, pin_function_reg};
                `SACC_ADDR_MODE: next_rdata = {conversion_start, 1'b0, conv_time_sel,
                    comparator_enable};
                `SACC_ADDR_RES_LO: next_rdata = {result_reg[1:0], 6'h00};
                `SACC_ADDR_RES_HI: next_rdata = result_reg[9:2];
                default: next_rdata = 8'h00;
            endcase
        end
        case (state)
            SACC_IDLE: begin
                if (conversion_start) begin
                    next_state = SACC_SAMPLE;
                    next_sample_cnt = 8'h00;
                end
            end
            SACC_SAMPLE: begin
                next_sample_cnt = sample_cnt + 8'h01;
                if (sample_cnt == `SACC_SAMPLE_CYCLES - 8'h01) begin
                    next_state = SACC_APPROX;
                    next_bit_idx = 4'h9;
                    next_approximation_reg = 10'h200;
                end
            end
            SACC_APPROX: begin
                // keep the trial bit when the held input is at or above the tap
                next_approximation_reg[bit_idx] = i_cmp_above;
                if (bit_idx == 4'h0) begin
                    next_state = SACC_DONE;
                end else begin
                    next_approximation_reg[bit_idx - 4'h1] = 1'b1;
                    next_bit_idx = bit_idx - 4'h1;
                end
            end
            SACC_DONE: begin
                next_result_reg = approximation_reg;
                next_irq = 1'b1;
                next_state = SACC_SAMPLE;
                next_sample_cnt = 8'h00;
            end
            default: next_state = SACC_IDLE;
        endcase
        // clearing start stops at once; the last result is left untouched
        if (!next_conversion_start) begin
            next_state = SACC_IDLE;
            next_irq = 1'b0;
            next_result_reg = result_reg;
        end else if (wr_chan && state != SACC_IDLE) begin
            next_state = SACC_SAMPLE;
            next_sample_cnt = 8'h00;
            next_irq = 1'b0;
            next_result_reg = result_reg;
        end
    end

    // state registers
    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            port_direction_reg <= `SACC_RST_PORT_DIR;
            channel_select_reg <= 3'h0;
            pin_function_reg <= 4'h0;
            conversion_start <= 1'b0;
            comparator_enable <= 1'b0;
            conv_time_sel <= 5'h00;
            approximation_reg <= 10'h000;
            result_reg <= 10'h000;
            bit_idx <= 4'h0;
            sample_cnt <= 8'h00;
            approx_len <= 4'h0;
            state <= SACC_IDLE;
            irq <= 1'b0;
            wait_q <= 1'b0;
            rdata <= 8'h00;
        end else begin
            port_direction_reg <= next_port_direction_reg;
            channel_select_reg <= next_channel_select_reg;
            pin_function_reg <= next_pin_function_reg;
            conversion_start <= next_conversion_start;
            comparator_enable <= next_comparator_enable;
            conv_time_sel <= next_conv_time_sel;
            approximation_reg <= next_approximation_reg;
            result_reg <= next_result_reg;
            bit_idx <= next_bit_idx;
            sample_cnt <= next_sample_cnt;
            approx_len <= next_approx_len;
            state <= next_state;
            irq <= next_irq;
            wait_q <= next_wait_q;
            rdata <= next_rdata;
        end
    end

    // pin and analog side outputs
    always_comb begin
        o_digital_pin = digital_mask(pin_function_reg);
        o_output_buf_en = ~port_direction_reg & o_digital_pin;
        o_analog_sel = 8'h00;
        // only an analog input-mode pin reaches the converter
        o_analog_sel[channel_select_reg] = ~o_digital_pin[channel_select_reg]
            & port_direction_reg[channel_select_reg];
    end

    assign o_wait = (wr_chan || wr_pin) && !wait_q;
    assign o_trial_code = approximation_reg;
    assign o_sample = (state == SACC_SAMPLE);
    assign o_cmp_enable = comparator_enable;
    assign o_conversion_end_irq = irq;
    assign o_rdata = rdata;

    sequence s_done_step;
        state == SACC_DONE && conversion_start && !wr_chan && i_bus.wr == 1'b0;
    endsequence

    AST_RESULT_IRQ: assert property (@(posedge i_clock) disable iff (!i_reset_n)
        s_done_step |=> irq && result_reg == $past(approximation_reg))
        else $error("result and irq not raised together");
    AST_START_MSB: assert property (@(posedge i_clock) disable iff (!i_reset_n)
        state == SACC_SAMPLE ##1 state == SACC_APPROX |-> approximation_reg == 10'h200)
        else $error("approximation did not start at half reference");
    AST_TEN_STEPS: assert property (@(posedge i_clock) disable iff (!i_reset_n)
        state == SACC_DONE |-> approx_len == 4'hA)
        else $error("approximation did not take ten steps");
    AST_STOP_NOW: assert property (@(posedge i_clock) disable iff (!i_reset_n)
        i_bus.wr && i_bus.addr == `SACC_ADDR_MODE && !i_bus.wdata[`SACC_MODE_START]
        |=> state == SACC_IDLE && $stable(result_reg))
        else $error("clearing start did not stop conversion");
    AST_CHAN_ABORT: assert property (@(posedge i_clock) disable iff (!i_reset_n)
        wr_chan && conversion_start && state != SACC_IDLE |=> state == SACC_SAMPLE
        && sample_cnt == 8'h00)
        else $error("channel write did not restart conversion");
    AST_WAIT: assert property (@(posedge i_clock) disable iff (!i_reset_n)
        (wr_chan || wr_pin) && !$past(wr_chan || wr_pin) |-> o_wait)
        else $error("no wait cycle on configuration write");
    AST_REPEAT: assert property (@(posedge i_clock) disable iff (!i_reset_n)
        s_done_step |=> state == SACC_SAMPLE)
        else $error("conversion did not repeat");
    AST_DIGITAL_MASK: assert property (@(posedge i_clock) disable iff (!i_reset_n)
        pin_function_reg == 4'h8 |-> o_digital_pin == 8'hFF && o_analog_sel == 8'h00)
        else $error("pin function decode wrong");
    AST_SAMPLE_TIME: assert property (@(posedge i_clock) disable iff (!i_reset_n)
        $rose(state == SACC_APPROX) |-> $past(sample_cnt) == `SACC_SAMPLE_CYCLES - 8'h01)
        else $error("sampling time wrong");
endmodule

// file: sacc_cmp_model.sv
// comparator and sample-and-hold model facing the converter control block
`timescale 1ns/1ps
module sacc_cmp_model #(
    parameter logic [79:0] LEVELS = 80'h0
) (
    input wire logic i_clock,
    input wire logic i_sample,
    input wire logic i_cmp_enable,
    input wire logic [7:0] i_analog_sel,
    input wire logic [9:0] i_trial_code,
    output logic o_cmp_above
);
    logic [9:0] held = 10'h000;
    logic [9:0] pick;
    logic tgl = 1'b0;
    // one-hot switch picks a level; an open switch reads as a changing node
    always_comb begin
        pick = {5{tgl, ~tgl}};
        for (int n = 0; n < 8; n++) begin
            if (i_analog_sel[n]) begin
                pick = LEVELS[n*10 +: 10];
            end
        end
    end
    // track while sampling, freeze while holding
    always @(posedge i_clock) begin
        tgl <= ~tgl;
        if (i_sample) begin
            held <= pick;
        end
    end
    // decision against the tap; a disabled comparator gives nothing usable
    assign o_cmp_above = i_cmp_enable ? (held >= i_trial_code) : tgl;
endmodule

// file: sar_adc_channel_and_sequence_control_tb_top.sv
// self-checking bench for the converter control block
`timescale 1ns/1ps
`include "sacc_regs.svh"
module sar_adc_channel_and_sequence_control_tb_top;
    import sacc_pkg::*;
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    sacc_bus_req_t bus = '0;
    logic cmp_above, wait_flag, sample, cmp_en, irq;
    logic [7:0] rdata, analog_sel, digital, buf_en, d;
    logic [9:0] trial;
    logic got;
    int errors = 0;
    int checks = 0;
    int ns;
    // peripheral clock never stops, so configuration writes are always legal
    always #25 clock = ~clock;
    sacc_ctrl u_dut (.i_clock(clock), .i_reset_n(reset_n), .i_bus(bus), .i_cmp_above(cmp_above),
        .o_rdata(rdata), .o_wait(wait_flag), .o_trial_code(trial), .o_sample(sample),
        .o_cmp_enable(cmp_en), .o_analog_sel(analog_sel), .o_digital_pin(digital),
        .o_output_buf_en(buf_en), .o_conversion_end_irq(irq));
    // input 3 and input 5 carry distinct levels, the rest sit at zero
    sacc_cmp_model #(.LEVELS({20'h0, 10'h15B, 10'h0, 10'h2A5, 30'h0})) u_far (.i_clock(clock),
        .i_sample(sample), .i_cmp_enable(cmp_en), .i_analog_sel(analog_sel),
        .i_trial_code(trial), .o_cmp_above(cmp_above));
    task automatic end_sim;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // one write; the cpu holds the strobe one more cycle while wait is up
    task automatic write(input logic [15:0] a, input logic [7:0] v);
        logic w;
        bus = '{a, v, 1'b1, 1'b0};
        #1 w = wait_flag;
        check("wait", w, a == `SACC_ADDR_CHAN_SEL || a == `SACC_ADDR_PIN_FUNC);
        @(posedge clock);
        if (w) @(posedge clock);
        #5 bus.wr = 1'b0;
        @(posedge clock);
        #5;
    endtask
    // idle cycle after each access so the strobe is never set twice in a step
    task automatic read(input logic [15:0] a);
        bus = '{a, 8'h00, 1'b0, 1'b1};
        @(posedge clock);
        #5 bus.rd = 1'b0;
        d = rdata;
        @(posedge clock);
        #5;
    endtask
    task automatic wait_irq(input int lim);
        got = 1'b0;
        ns = 0;
        for (int n = 0; n < lim && !got; n++) begin
            @(posedge clock);
            #5 got = (irq === 1'b1);
            ns += (sample === 1'b1);
        end
    endtask
    initial begin
        #500000;
        errors++;
        end_sim();
    end
    initial begin
        repeat (12) @(posedge clock);
        #5 reset_n = 1'b1;
        read(`SACC_ADDR_PORT_DIR);
        check("port_dir", d, `SACC_RST_PORT_DIR);
        read(`SACC_ADDR_CHAN_SEL);
        check("chan_sel", d, `SACC_RST_CHAN_SEL);
        read(`SACC_ADDR_PIN_FUNC);
        check("pin_func", d, `SACC_RST_PIN_FUNC);
        write(16'hFF40, 8'h5A);
        read(16'hFF40);
        check("unmapped", d, 16'h0000);
        // every channel code on analog input pins
        for (int c = 0; c < 8; c++) begin
            write(`SACC_ADDR_CHAN_SEL, 8'(c));
            check("analog_sel", analog_sel, 16'(1 << c));
        end
        // every legal pin function code, then a prohibited one
        for (int k = 0; k <= 8; k++) begin
            write(`SACC_ADDR_PIN_FUNC, 8'(k));
            check("digital_pin", digital, 16'((1 << k) - 1));
        end
        write(`SACC_ADDR_PIN_FUNC, 8'h09);
        check("digital_pin", digital, 16'h00FF);
        write(`SACC_ADDR_PIN_FUNC, 8'h04);
        write(`SACC_ADDR_PORT_DIR, 8'hF5);
        check("buf_en", buf_en, 16'h000A);
        write(`SACC_ADDR_CHAN_SEL, 8'h03);
        check("analog_sel", analog_sel, 16'h0000);
        write(`SACC_ADDR_CHAN_SEL, 8'h05);
        check("analog_sel", analog_sel, 16'h0020);
        write(`SACC_ADDR_PORT_DIR, 8'hD5);
        check("analog_sel", analog_sel, 16'h0000);
        // convert input 3 continuously; comparator settles over 1 us before start
        write(`SACC_ADDR_MODE, 8'h01);
        check("cmp_en", cmp_en, 1);
        write(`SACC_ADDR_PORT_DIR, 8'hFF);
        write(`SACC_ADDR_PIN_FUNC, 8'h00);
        write(`SACC_ADDR_CHAN_SEL, 8'h03);
        repeat (20) @(posedge clock);
        #5;
        write(`SACC_ADDR_MODE, 8'h81);
        wait_irq(200);
        check("irq", got, 1);
        wait_irq(100);
        check("irq", got, 1);
        check("sample_len", ns, `SACC_SAMPLE_CYCLES);
        read(`SACC_ADDR_RES_HI);
        check("res_hi", d, 16'h00A9);
        read(`SACC_ADDR_RES_LO);
        check("res_lo", d, 16'h0040);
        // channel rewrite in mid approximation restarts on the new input
        wait_irq(100);
        repeat (30) @(posedge clock);
        #5;
        write(`SACC_ADDR_CHAN_SEL, 8'h05);
        wait_irq(100);
        read(`SACC_ADDR_RES_HI);
        check("res_hi", d, 16'h0056);
        read(`SACC_ADDR_RES_LO);
        check("res_lo", d, 16'h00C0);
        // stop keeps the last result, then restart from the start bit
        wait_irq(100);
        write(`SACC_ADDR_MODE, 8'h01);
        wait_irq(100);
        check("irq", got, 0);
        check("sample", sample, 0);
        read(`SACC_ADDR_RES_HI);
        check("res_hi", d, 16'h0056);
        write(`SACC_ADDR_MODE, 8'h81);
        wait_irq(200);
        check("irq", got, 1);
        end_sim();
    end
endmodule
